// >>> core/psmdp_pkg.sv
/*
  psmdp_pkg: constants shared by the strap latch and MAC data port block.
  Assumes a 50 MHz system clock and a slower link clock sampled by it.
*/
package psmdp_pkg;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int SYNC_DEPTH_CYC = 2;
  // pins settle through the synchroniser before the straps are taken
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'(SYNC_DEPTH_CYC);

  // --------------------------------------------------------------------
  // dual-purpose pin positions (receive side of the MAC port)
  // --------------------------------------------------------------------
  localparam int PIN_W = 7;
  localparam int PIN_RXD0 = 0;
  localparam int PIN_RXDV = 4;
  localparam int MGMT_ADDR_STRAP_BIT0_POS = 0;
  localparam int MGMT_ADDR_STRAP_BIT1_POS = 1;
  localparam int MGMT_ADDR_STRAP_BIT2_POS = 2;
  localparam int IF_MODE_STRAP_BIT0_POS = 3;
  localparam int IF_MODE_STRAP_BIT1_POS = 4;
  localparam int IF_MODE_STRAP_BIT2_POS = 5;
  localparam int ISO_STRAP_POS = 6;

  // --------------------------------------------------------------------
  // strap values and modes
  // --------------------------------------------------------------------
  localparam logic [1:0] MGMT_ADDR_HI = 2'h0;
  localparam logic [2:0] MGMT_ADDR_RST = 3'h1;
  localparam logic [2:0] MODE_CODE_MII = 3'h0;
  localparam logic [2:0] MODE_CODE_RMII = 3'h1;
  localparam logic [2:0] MODE_CODE_LOOP = 3'h4;
  localparam logic ISO_RST = 1'b0;

  typedef enum logic [1:0] {MD_MII, MD_RMII, MD_LOOP, MD_RSVD} psmdp_mode_t;
  typedef enum logic [1:0] {ST_WAIT, ST_LATCH, ST_RUN} psmdp_state_t;

  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam int CTRL0_ISO_BIT = 10;
  localparam int STAT_ADDR_LSB = 0;
  localparam int STAT_MODE_LSB = 8;
  localparam int STAT_RSVD_BIT = 11;
  localparam int STAT_DONE_BIT = 15;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // --------------------------------------------------------------------
  // data path
  // --------------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int FIFO_W = 9;
  localparam int FIFO_DEPTH = 4;

endpackage : psmdp_pkg

// >>> core/psmdp_stream_if.sv
/*
  psmdp_stream_if: valid/ready word stream between the block's modules.
  Assumes both ends share one clock; data moves when valid and ready are high.
*/
interface psmdp_stream_if #(parameter int W = 9) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : psmdp_stream_if

// >>> core/psmdp_fifo.sv
/*
  psmdp_fifo: flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
module psmdp_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,      // system clock
  input wire logic rst,      // async reset, active high
  psmdp_stream_if.snk in_s,  // filling side
  psmdp_stream_if.src out_s  // draining side
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2) begin : g_chk
    $error("psmdp_fifo needs DEPTH of at least 2");
  end

  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_s.ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_reg != '0);
  assign out_s.data = mem_reg[rd_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_mem
    always_comb begin
      mem_next[i] = (push && wr_reg == AW'(i)) ? in_s.data : mem_reg[i];
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mem_reg[i] <= '0;
      end else begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

endmodule : psmdp_fifo

// >>> core/psmdp_top.sv
/*
  psmdp_top: strap latch plus MII/RMII data port toward a MAC, with an
  AXI4-Lite register slave. Assumes LINK_CLK is the MII/RMII reference
  clock from outside, far slower than CLK, and that the strap pins carry
  weak pulls during reset.
*/
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
module psmdp_top
  import psmdp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic CLK,                  // system clock, 50 MHz
  input wire logic RST,                  // async reset, active high
  input wire logic [7:0] S_AXI_AWADDR,   // write address
  input wire logic S_AXI_AWVALID,        // write address valid
  output logic S_AXI_AWREADY,            // write address ready
  input wire logic [31:0] S_AXI_WDATA,   // write data
  input wire logic [3:0] S_AXI_WSTRB,    // write byte strobes
  input wire logic S_AXI_WVALID,         // write data valid
  output logic S_AXI_WREADY,             // write data ready
  output logic [1:0] S_AXI_BRESP,        // write response
  output logic S_AXI_BVALID,             // write response valid
  input wire logic S_AXI_BREADY,         // write response ready
  input wire logic [7:0] S_AXI_ARADDR,   // read address
  input wire logic S_AXI_ARVALID,        // read address valid
  output logic S_AXI_ARREADY,            // read address ready
  output logic [31:0] S_AXI_RDATA,       // read data
  output logic [1:0] S_AXI_RRESP,        // read response
  output logic S_AXI_RVALID,             // read data valid
  input wire logic S_AXI_RREADY,         // read data ready
  input wire logic LINK_CLK,             // reference clock from outside
  output logic MII_CLK_OUT,              // rx/tx clock handed to the MAC
  input wire logic TX_EN,                // transmit enable from the MAC
  input wire logic [3:0] TXD,            // transmit data from the MAC
  input wire logic [PIN_W-1:0] PIN_I,    // strap / rx pins, level in
  output logic [PIN_W-1:0] PIN_O,        // strap / rx pins, level out
  output logic [PIN_W-1:0] PIN_OE,       // strap / rx pins, drive enable
  input wire logic [7:0] RX_BYTE,        // receive byte from line side
  input wire logic RX_LAST,              // last byte of a frame
  input wire logic RX_VALID,             // receive byte valid
  output logic RX_READY,                 // receive byte accepted
  output logic [7:0] TX_BYTE,            // assembled transmit byte
  output logic TX_BYTE_VALID,            // one-cycle pulse per byte
  output logic TX_FRAME_END,             // one-cycle pulse at enable fall
  output logic [4:0] MGMT_ADDR,          // latched management address
  output logic [2:0] IF_MODE,            // latched mode strap code
  output logic ISOLATE                   // isolate control bit
);

  if (DEPTH < 2) begin : g_chk
    $error("psmdp_top needs a FIFO depth of at least 2");
  end

  // ----------------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------------
  logic lk_s1_reg, lk_s1_next, lk_s2_reg, lk_s2_next, lk_q_reg, lk_q_next;
  logic ten_s1_reg, ten_s1_next, ten_s2_reg, ten_s2_next;
  logic [3:0] txd_s1_reg, txd_s1_next, txd_s2_reg, txd_s2_next;
  logic [PIN_W-1:0] pin_s1_reg, pin_s1_next, pin_s2_reg, pin_s2_next;
  logic lk_rise, lk_fall;

  always_comb begin
    lk_s1_next = LINK_CLK;
    lk_s2_next = lk_s1_reg;
    lk_q_next = lk_s2_reg;
    ten_s1_next = TX_EN;
    ten_s2_next = ten_s1_reg;
    txd_s1_next = TXD;
    txd_s2_next = txd_s1_reg;
    pin_s1_next = PIN_I;
    pin_s2_next = pin_s1_reg;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      lk_s1_reg <= 1'b0;
      lk_s2_reg <= 1'b0;
      lk_q_reg <= 1'b0;
      ten_s1_reg <= 1'b0;
      ten_s2_reg <= 1'b0;
      txd_s1_reg <= 4'h0;
      txd_s2_reg <= 4'h0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      lk_s1_reg <= lk_s1_next;
      lk_s2_reg <= lk_s2_next;
      lk_q_reg <= lk_q_next;
      ten_s1_reg <= ten_s1_next;
      ten_s2_reg <= ten_s2_next;
      txd_s1_reg <= txd_s1_next;
      txd_s2_reg <= txd_s2_next;
      pin_s1_reg <= pin_s1_next;
      pin_s2_reg <= pin_s2_next;
    end
  end

  assign lk_rise = lk_s2_reg && !lk_q_reg;
  assign lk_fall = !lk_s2_reg && lk_q_reg;
  // the MAC gets the clock as we see it, so our data edges line up with it
  assign MII_CLK_OUT = lk_q_reg;

  // ----------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------
  psmdp_state_t st_reg, st_next;
  logic [1:0] settle_reg, settle_next;
  logic [2:0] addr_reg, addr_next;
  logic [2:0] mcode_reg, mcode_next;
  psmdp_mode_t mode;
  logic run, rmii, active;

  always_comb begin
    st_next = st_reg;
    settle_next = settle_reg;
    addr_next = addr_reg;
    mcode_next = mcode_reg;
    case (st_reg)
      ST_WAIT: begin
        settle_next = settle_reg + 1'b1;
        if (settle_reg == STRAP_SETTLE_CYC) begin
          st_next = ST_LATCH;
        end
      end
      ST_LATCH: begin
        addr_next = {pin_s2_reg[MGMT_ADDR_STRAP_BIT2_POS],
                     pin_s2_reg[MGMT_ADDR_STRAP_BIT1_POS],
                     pin_s2_reg[MGMT_ADDR_STRAP_BIT0_POS]};
        mcode_next = {pin_s2_reg[IF_MODE_STRAP_BIT2_POS],
                      pin_s2_reg[IF_MODE_STRAP_BIT1_POS],
                      pin_s2_reg[IF_MODE_STRAP_BIT0_POS]};
        st_next = ST_RUN;
      end
      default: begin
        st_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= ST_WAIT;
      settle_reg <= 2'h0;
      addr_reg <= MGMT_ADDR_RST;
      mcode_reg <= MODE_CODE_MII;
    end else begin
      st_reg <= st_next;
      settle_reg <= settle_next;
      addr_reg <= addr_next;
      mcode_reg <= mcode_next;
    end
  end

  always_comb begin
    if (mcode_reg == MODE_CODE_MII) begin
      mode = MD_MII;
    end else if (mcode_reg == MODE_CODE_RMII) begin
      mode = MD_RMII;
    end else if (mcode_reg == MODE_CODE_LOOP) begin
      mode = MD_LOOP;
    end else begin
      mode = MD_RSVD;
    end
  end

  logic iso_reg, iso_next;
  assign run = (st_reg == ST_RUN);
  assign rmii = (mode == MD_RMII);
  // reserved codes leave the data port quiet rather than guess a mode
  assign active = run && !iso_reg && (mode != MD_RSVD);
  assign MGMT_ADDR = {MGMT_ADDR_HI, addr_reg};
  assign IF_MODE = mcode_reg;
  assign ISOLATE = iso_reg;

  // ----------------------------------------------------------------------
  // receive FIFO
  // ----------------------------------------------------------------------
  psmdp_stream_if #(.W(FIFO_W)) fin ();
  psmdp_stream_if #(.W(FIFO_W)) fout ();
  logic [7:0] txb_reg, txb_next;
  logic txv_reg, txv_next;

  // loopback feeds assembled transmit bytes back; they carry no frame end
  assign fin.data = (mode == MD_LOOP) ? {1'b0, txb_reg} : {RX_LAST, RX_BYTE};
  assign fin.valid = (mode == MD_LOOP) ? txv_reg : RX_VALID;
  assign RX_READY = (mode != MD_LOOP) && fin.ready;

  psmdp_fifo #(.W(FIFO_W), .DEPTH(DEPTH)) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_s(fin),
    .out_s(fout)
  );

  // ----------------------------------------------------------------------
  // receive serialiser, changes data on the falling link edge
  // ----------------------------------------------------------------------
  logic [7:0] rsh_reg, rsh_next;
  logic [1:0] rcnt_reg, rcnt_next;
  logic gap_reg, gap_next;
  logic [3:0] rxd_reg, rxd_next;
  logic rxdv_reg, rxdv_next;

  assign fout.ready = lk_fall && active && rcnt_reg == 2'h0 && !gap_reg;

  always_comb begin
    rsh_next = rsh_reg;
    rcnt_next = rcnt_reg;
    gap_next = gap_reg;
    rxd_next = rxd_reg;
    rxdv_next = rxdv_reg;
    if (!active) begin
      rcnt_next = 2'h0;
      gap_next = 1'b0;
      rxdv_next = 1'b0;
      rxd_next = 4'h0;
    end else if (lk_fall) begin
      if (rcnt_reg != 2'h0) begin
        rxd_next = rmii ? {2'h0, rsh_reg[1:0]} : rsh_reg[3:0];
        rsh_next = rmii ? {2'h0, rsh_reg[7:2]} : {4'h0, rsh_reg[7:4]};
        rcnt_next = rcnt_reg - 1'b1;
        rxdv_next = 1'b1;
      end else if (gap_reg) begin
        // one idle symbol between frames
        gap_next = 1'b0;
        rxdv_next = 1'b0;
        rxd_next = 4'h0;
      end else if (fout.valid) begin
        rxd_next = rmii ? {2'h0, fout.data[1:0]} : fout.data[3:0];
        rsh_next = rmii ? {2'h0, fout.data[7:2]} : {4'h0, fout.data[7:4]};
        rcnt_next = rmii ? 2'h3 : 2'h1;
        gap_next = fout.data[BYTE_W];
        rxdv_next = 1'b1;
      end else begin
        rxdv_next = 1'b0;
        rxd_next = 4'h0;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rsh_reg <= 8'h00;
      rcnt_reg <= 2'h0;
      gap_reg <= 1'b0;
      rxd_reg <= 4'h0;
      rxdv_reg <= 1'b0;
    end else begin
      rsh_reg <= rsh_next;
      rcnt_reg <= rcnt_next;
      gap_reg <= gap_next;
      rxd_reg <= rxd_next;
      rxdv_reg <= rxdv_next;
    end
  end

  always_comb begin
    PIN_O = '0;
    PIN_O[PIN_RXD0 +: 4] = rxd_reg;
    PIN_O[PIN_RXDV] = rxdv_reg;
    // pins stay inputs until the straps are in, and float while isolated
    PIN_OE = {PIN_W{run && !iso_reg}};
  end

  // ----------------------------------------------------------------------
  // transmit deserialiser, samples on the rising link edge
  // ----------------------------------------------------------------------
  logic [7:0] tacc_reg, tacc_next, tacc_new;
  logic [1:0] tcnt_reg, tcnt_next;
  logic tprev_reg, tprev_next;
  logic tend_reg, tend_next;

  always_comb begin
    tacc_next = tacc_reg;
    tcnt_next = tcnt_reg;
    tprev_next = tprev_reg;
    txb_next = txb_reg;
    txv_next = 1'b0;
    tend_next = 1'b0;
    tacc_new = rmii ? {txd_s2_reg[1:0], tacc_reg[7:2]} : {txd_s2_reg, tacc_reg[7:4]};
    if (!active) begin
      tcnt_next = 2'h0;
      tprev_next = 1'b0;
    end else if (lk_rise) begin
      tprev_next = ten_s2_reg;
      if (ten_s2_reg) begin
        tacc_next = tacc_new;
        if (tcnt_reg == (rmii ? 2'h3 : 2'h1)) begin
          txb_next = tacc_new;
          txv_next = 1'b1;
          tcnt_next = 2'h0;
        end else begin
          tcnt_next = tcnt_reg + 1'b1;
        end
      end else begin
        // a partial byte at enable fall is dropped
        tcnt_next = 2'h0;
        tend_next = tprev_reg;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tacc_reg <= 8'h00;
      tcnt_reg <= 2'h0;
      tprev_reg <= 1'b0;
      txb_reg <= 8'h00;
      txv_reg <= 1'b0;
      tend_reg <= 1'b0;
    end else begin
      tacc_reg <= tacc_next;
      tcnt_reg <= tcnt_next;
      tprev_reg <= tprev_next;
      txb_reg <= txb_next;
      txv_reg <= txv_next;
      tend_reg <= tend_next;
    end
  end

  assign TX_BYTE = txb_reg;
  assign TX_BYTE_VALID = txv_reg;
  assign TX_FRAME_END = tend_reg;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  logic awh_reg, awh_next, wh_reg, wh_next, bv_reg, bv_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic [1:0] br_reg, br_next;

  assign S_AXI_AWREADY = !awh_reg;
  assign S_AXI_WREADY = !wh_reg;

  always_comb begin
    awh_next = awh_reg;
    awa_next = awa_reg;
    wh_next = wh_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    iso_next = iso_reg;
    if (S_AXI_AWVALID && !awh_reg) begin
      awh_next = 1'b1;
      awa_next = {S_AXI_AWADDR[7:2], 2'h0};
    end
    if (S_AXI_WVALID && !wh_reg) begin
      wh_next = 1'b1;
      wd_next = S_AXI_WDATA;
      ws_next = S_AXI_WSTRB;
    end
    if (bv_reg && S_AXI_BREADY) begin
      bv_next = 1'b0;
    end
    if (awh_reg && wh_reg && !bv_reg) begin
      awh_next = 1'b0;
      wh_next = 1'b0;
      bv_next = 1'b1;
      if (awa_reg == OFS_CTRL0) begin
        br_next = RESP_OKAY;
        if (ws_reg[1]) begin
          iso_next = wd_reg[CTRL0_ISO_BIT];
        end
      end else if (awa_reg == OFS_STATUS) begin
        br_next = RESP_OKAY;
      end else begin
        br_next = RESP_SLVERR;
      end
    end
    // the strap outranks any write that lands in the capture cycle
    if (st_reg == ST_LATCH) begin
      iso_next = pin_s2_reg[ISO_STRAP_POS];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      awh_reg <= 1'b0;
      awa_reg <= 8'h00;
      wh_reg <= 1'b0;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      bv_reg <= 1'b0;
      br_reg <= RESP_OKAY;
      iso_reg <= ISO_RST;
    end else begin
      awh_reg <= awh_next;
      awa_reg <= awa_next;
      wh_reg <= wh_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      iso_reg <= iso_next;
    end
  end

  assign S_AXI_BVALID = bv_reg;
  assign S_AXI_BRESP = br_reg;

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  logic rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0] rr_reg, rr_next;
  logic [7:0] ra;

  assign S_AXI_ARREADY = !rv_reg;
  assign ra = {S_AXI_ARADDR[7:2], 2'h0};

  always_comb begin
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (rv_reg && S_AXI_RREADY) begin
      rv_next = 1'b0;
    end
    if (S_AXI_ARVALID && !rv_reg) begin
      rv_next = 1'b1;
      rd_next = 32'h0;
      rr_next = RESP_OKAY;
      if (ra == OFS_CTRL0) begin
        rd_next[CTRL0_ISO_BIT] = iso_reg;
      end else if (ra == OFS_STATUS) begin
        rd_next[STAT_ADDR_LSB +: 5] = MGMT_ADDR;
        rd_next[STAT_MODE_LSB +: 3] = mcode_reg;
        rd_next[STAT_RSVD_BIT] = (mode == MD_RSVD);
        rd_next[STAT_DONE_BIT] = run;
      end else begin
        rr_next = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rv_reg <= 1'b0;
      rd_reg <= 32'h0;
      rr_reg <= RESP_OKAY;
    end else begin
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
    end
  end

  assign S_AXI_RVALID = rv_reg;
  assign S_AXI_RDATA = rd_reg;
  assign S_AXI_RRESP = rr_reg;

endmodule : psmdp_top

// >>> tb/psmdp_checker.sv
/* psmdp_checker: port relations of psmdp_top.
   Bound to psmdp_top; sees only its ports. */
module psmdp_checker
  import psmdp_pkg::*;
(
  input wire logic CLK, // clock
  input wire logic RST, // reset
  input wire logic MII_CLK_OUT, // mac clock
  input wire logic TX_EN, // tx enable
  input wire logic TX_BYTE_VALID, // byte pulse
  input wire logic [PIN_W-1:0] PIN_I, // pin level
  input wire logic [PIN_W-1:0] PIN_O, // pin drive
  input wire logic [PIN_W-1:0] PIN_OE, // pin enable
  input wire logic [4:0] MGMT_ADDR, // address
  input wire logic [2:0] IF_MODE, // mode
  input wire logic ISOLATE // isolate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  addr_hi_a: assert property (MGMT_ADDR[4:3] == MGMT_ADDR_HI)
    else $error("address high bits set");
  pins_in_a: assert property ($fell(RST) |-> (PIN_OE == '0) [*3])
    else $error("pins driven in capture");
  // drivers take the pins right after the latch edge, so compare with the levels seen there
  strap_take_a: assert property ($fell(RST) ##4 1 |->
    MGMT_ADDR[2:0] == $past(PIN_I[2:0]) && IF_MODE == $past(PIN_I[5:3]) &&
    ISOLATE == $past(PIN_I[6]))
    else $error("strap not latched");
  strap_hold_a: assert property (|PIN_OE |=> $stable({MGMT_ADDR, IF_MODE}))
    else $error("strap changed");
  iso_off_a: assert property (ISOLATE |-> PIN_OE == '0)
    else $error("driven while isolated");
  rx_sync_a: assert property ($rose(MII_CLK_OUT) |-> $stable(PIN_O[4:0]))
    else $error("rx moved at clock rise");
  rmii_dibit_a: assert property (IF_MODE == MODE_CODE_RMII && PIN_O[PIN_RXDV] |->
    PIN_O[3:2] == 2'h0)
    else $error("rmii upper bits set");
  tx_idle_a: assert property (!TX_EN [*8] |-> !TX_BYTE_VALID)
    else $error("byte without enable");
  rsvd_quiet_a: assert property (IF_MODE[1] || IF_MODE[2] && IF_MODE[0] |->
    !PIN_O[PIN_RXDV])
    else $error("reserved mode active");
  cover property ($rose(TX_BYTE_VALID));
  cover property (ISOLATE && TX_EN);
  cover property (IF_MODE == MODE_CODE_RMII && PIN_O[PIN_RXDV]);
endmodule : psmdp_checker

bind psmdp_top psmdp_checker i_chk (.*);

// >>> tb/psmdp_mac_model.sv
/* psmdp_mac_model: MAC side of the MII/RMII data port.
   Assumes the bench fills tq and empties rq. */
module psmdp_mac_model (
  input wire logic mclk, // rx sample clock
  input wire logic lclk, // reference clock
  input wire logic rmii, // two-bit symbols
  input wire logic [4:0] rx, // rxd and valid
  output logic tx_en = 1'b0, // transmit enable
  output logic [3:0] txd = 4'h0 // transmit data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tq[$], rq[$], tb, rb;
  int tn = 0, rn = 0;
  always @(posedge mclk) begin
    rb = rmii ? {rx[1:0], rb[7:2]} : {rx[3:0], rb[7:4]};
    rn = rx[4] ? rn + 1 : 0;
    if (rn == (rmii ? 4 : 2)) begin
      rq.push_back(rb);
      rn = 0;
    end
  end
  // mii follows the transmit clock we are given, rmii the shared reference
  always @(negedge (rmii ? lclk : mclk)) begin
    if (tn == 0 && tq.size() > 0) begin
      tb = tq.pop_front();
      tn = rmii ? 4 : 2;
    end
    tx_en <= tn > 0;
    // idle data lines toggle so a stale symbol cannot pass as valid
    txd <= tn > 0 ? tb[3:0] : ~txd;
    tb = rmii ? tb >> 2 : tb >> 4;
    tn = tn > 0 ? tn - 1 : 0;
  end
endmodule : psmdp_mac_model

// >>> tb/psmdp_tb_top.sv
/* psmdp_tb_top: straps, registers and MAC data port of psmdp_top.
   Assumes the MAC model and the bound checker are compiled before it. */
module psmdp_tb_top import psmdp_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = '0, RST = '1, LINK_CLK = '0, RX_LAST = '0, RX_VALID = '0, rdy, q, lb;
  logic S_AXI_AWVALID = '0, S_AXI_WVALID = '0, S_AXI_ARVALID = '0, S_AXI_BREADY = '0;
  logic S_AXI_RREADY = '0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, MII_CLK_OUT, TX_EN, RX_READY, TX_BYTE_VALID, TX_FRAME_END, ISOLATE;
  logic [7:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, RX_BYTE = '0, TX_BYTE, tx_exp[$], rx_exp[$];
  logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA, rd;
  logic [3:0] S_AXI_WSTRB = '0, TXD, s;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rr;
  logic [PIN_W-1:0] PIN_I, PIN_O, PIN_OE, strap = '0;
  logic [4:0] MGMT_ADDR;
  logic [2:0] IF_MODE, md[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h0};
  int err_total = 0, samples_checked = 0, seed = 32'h97E3, fe = 0;
  // undriven pins fall back to their strap pulls
  assign PIN_I = (PIN_OE & PIN_O) | (~PIN_OE & strap);
  psmdp_top i_dut (.*);
  psmdp_mac_model i_mac (.mclk(MII_CLK_OUT), .lclk(LINK_CLK), .rmii(IF_MODE == MODE_CODE_RMII),
    .rx(PIN_I[4:0]), .tx_en(TX_EN), .txd(TXD));
  initial forever #10 CLK = ~CLK;
  initial begin
    #7;
    forever #80 LINK_CLK = ~LINK_CLK;
  end
  initial begin
    #600_000;
    err_total++;
    results();
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // one register access; readies and answers sampled mid-cycle to avoid edge races
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} <= {a, a, v, 4'hF};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, S_AXI_BREADY, S_AXI_RREADY} <= {w, w, !w, 2'h3};
    do begin
      @(negedge CLK);
      s = {S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID | S_AXI_RVALID};
      {rd, rr} = {S_AXI_RDATA, w ? S_AXI_BRESP : S_AXI_RRESP};
      @(posedge CLK);
      {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} <=
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} & ~s[3:1];
    end while (!s[0]);
    {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
  endtask : ax
  always @(negedge CLK) begin
    if (TX_BYTE_VALID) chk("tx", tx_exp.size() ? tx_exp.pop_front() : 32'h1FF, TX_BYTE);
    if (i_mac.rq.size()) chk("rx", rx_exp.size() ? rx_exp.pop_front() : 32'h1FF,
      i_mac.rq.pop_front());
    if (TX_FRAME_END) fe++;
  end
  initial begin
    for (int c = 0; c < 5; c++) begin
      RST <= 1'b1;
      strap <= {c == 4, md[c], 3'($unsigned($random(seed)) % 7 + 1)};
      repeat (16) @(posedge CLK);
      RST <= 1'b0;
      repeat (8) @(posedge CLK);
      // quiet: isolated or a reserved code; loopback returns transmit bytes
      lb = strap[5:3] == MODE_CODE_LOOP;
      q = strap[6] | md[c][1] | md[c][2] & md[c][0];
      fe = 0;
      chk("addr", {2'h0, strap[2:0]}, MGMT_ADDR);
      chk("mode", strap[5:3], IF_MODE);
      chk("oe", strap[6] ? 7'h0 : 7'h7F, PIN_OE);
      ax(1'b0, OFS_STATUS, 32'h0);
      chk("status", {1'b1, md[c][1] | md[c][2] & md[c][0], md[c], 2'h0, strap[2:0]},
        {rd[15], rd[11:8], rd[4:0]});
      ax(1'b0, OFS_CTRL0, 32'h0);
      chk("iso", strap[6], rd[CTRL0_ISO_BIT]);
      ax(1'b0, 8'h10, 32'h0);
      chk("unmapped", RESP_SLVERR, rr);
      ax(1'b1, OFS_CTRL0, 32'(strap[6]) << CTRL0_ISO_BIT);
      chk("wresp", RESP_OKAY, rr);
      // receive bytes outrun the link, so the buffer fills and refuses
      for (int k = 0; k < 6; k++) begin
        rd = $random(seed);
        i_mac.tq.push_back(rd[7:0]);
        if (!q) tx_exp.push_back(rd[7:0]);
        if (!q) rx_exp.push_back(lb ? rd[7:0] : rd[15:8]);
        RX_BYTE <= rd[15:8];
        RX_LAST <= k == 5;
        RX_VALID <= !q && !lb;
        do begin
          @(negedge CLK);
          rdy = RX_READY | q | lb;
          @(posedge CLK);
        end while (!rdy);
      end
      RX_VALID <= 1'b0;
      for (int t = 0; t < 3000 && (tx_exp.size() || rx_exp.size() || i_mac.tq.size()); t++)
        @(posedge CLK);
      repeat (40) @(posedge CLK);
      chk("pending", 32'h0, tx_exp.size() + rx_exp.size());
      chk("frame_end", !q, fe != 0);
    end
    results();
  end
endmodule : psmdp_tb_top
